/* File: rtl/pamx_pkg.sv */
// Purpose: Shared constants for the port alternate-function multiplexer.
// Assumes: Avalon-MM slave with 32-bit data and byte addresses.
// Notes: Each register takes one aligned word; unused bits read as zero.
package pamx_pkg;
    // Register byte offsets.
    localparam logic [4:0] OFF_CONFIG = 5'h00;
    localparam logic [4:0] OFF_P2_ALT = 5'h04;
    localparam logic [4:0] OFF_P1_LATCH = 5'h08;
    localparam logic [4:0] OFF_P2_LATCH = 5'h0C;
    localparam logic [4:0] OFF_PINS = 5'h10;
    localparam logic [4:0] OFF_STATUS = 5'h14;
    localparam logic [4:0] OFF_CAPTURE = 5'h18;
    // Field positions in the configuration register.
    localparam int CFG_ECC_EN = 0;
    localparam int CFG_IRQ_SEL = 1;
    localparam int CFG_PW1_EN = 2;
    localparam int CFG_PW2_EN = 3;
    localparam int CFG_HOLD_EN = 4;
    localparam int CFG_DYN_WIDTH = 5;
    localparam int CFG_FAST4_OUT = 6;
    localparam int CFG_FAST5_OUT = 7;
    localparam int CFG_FAST_T2 = 8;
    localparam int CFG_W = 9;
    // Field positions in the status register.
    localparam int STAT_BUS16 = 0;
    localparam int STAT_HOLD = 1;
    // Reset values.
    localparam logic [8:0] CONFIG_RST = 9'h000;
    localparam logic [7:0] P2_ALT_RST = 8'h00;
    localparam logic [7:0] LATCH_RST = 8'hFF;
    // Width of the gathered pin inputs that pass the synchroniser.
    localparam int SYNC_W = 45;
    localparam logic [44:0] SYNC_RST = 45'h1FFF_FFFF_FFFF;
endpackage

/* File: rtl/pamx_top.sv */
// Purpose: Pin ownership and alternate-function routing for three ports,
//          the multiplexed address/data bus and the shared fast I/O pins.
// Assumes: One clock, mclk at 40 MHz; asynchronous active-low reset_n.
// Notes: Pin outputs are registered, so routing adds one cycle of latency;
//        pin inputs pass three flip-flops and a two-of-two agreement.

module pamx_top (
    // Clock and reset.
    input wire logic mclk,
    input wire logic reset_n,
    // Avalon-MM register slave.
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Port pins, each as input, output and active-low output enable.
    input wire logic [7:0] p0_in,
    output logic [7:0] p0_out,
    output logic [7:0] p0_oe_n,
    input wire logic [7:0] p1_in,
    output logic [7:0] p1_out,
    output logic [7:0] p1_oe_n,
    input wire logic [7:0] p2_in,
    output logic [7:0] p2_out,
    output logic [7:0] p2_oe_n,
    // Multiplexed bus pins and width select pin.
    input wire logic [15:0] ad_in,
    output logic [15:0] ad_out,
    output logic [15:0] ad_oe_n,
    input wire logic bus_width_select_in,
    // Fast I/O pins: two dedicated inputs, two shared in/out pins.
    input wire logic [1:0] fast_pin_in,
    input wire logic [1:0] shared_in,
    output logic [1:0] shared_out,
    output logic [1:0] shared_oe_n,
    // Bus controller side.
    input wire logic bus_cycle_active,
    input wire logic bus_addr_phase,
    input wire logic bus_data_write,
    input wire logic bus_req_pending,
    input wire logic [15:0] bus_addr,
    input wire logic [15:0] bus_wdata,
    output logic [15:0] bus_rdata,
    output logic bus_16bit,
    output logic hold_granted,
    // Error correction unit side.
    input wire logic [4:0] ecc_check_drive,
    input wire logic ecc_check_oe,
    output logic [4:0] ecc_check_bits,
    // Peripheral side.
    input wire logic pulse_width_out_zero,
    input wire logic pulse_width_out_one,
    input wire logic pulse_width_out_two,
    input wire logic serial_txd,
    output logic serial_rxd,
    output logic external_irq_input,
    output logic timer_two_clock_in,
    output logic baud_clock_in,
    output logic timer_two_reset_in,
    output logic timer_two_direction_in,
    input wire logic [15:0] timer_two_count,
    output logic irq_vector_eleven,
    output logic [1:0] fast_input_low,
    output logic [1:0] fast_input_high,
    input wire logic [1:0] fast_output_high
);
    // Software-visible control state.
    logic [8:0] cfg;
    logic [7:0] p2_alt;
    logic [7:0] p1_latch;
    logic [7:0] p2_latch;
    logic [15:0] capture_value;
    // Synchroniser stages and the agreed, filtered pin levels.
    logic [44:0] sync1;
    logic [44:0] sync2;
    logic [44:0] sync3;
    logic [44:0] pins;
    // Named views of the filtered pins.
    logic [7:0] p0f;
    logic [7:0] p1f;
    logic [7:0] p2f;
    logic [15:0] adf;
    logic [1:0] sharedf;
    logic [1:0] fastf;
    logic widthf;
    logic cap_prev;
    logic bus16_now;
    logic hold_req;
    logic hold_en;
    logic [7:0] p1_alt;
    // Next values of the registered pin drivers.
    logic [7:0] next_p1_out;
    logic [7:0] next_p2_out;
    logic [15:0] next_ad_out;
    logic [15:0] next_ad_oe_n;
    logic [31:0] next_readdata;
    logic bus_take;

    // Drive enable for a port: alternate bits drive if they are outputs,
    // plain bits drive only a low level and let the pull-up make a high.
    function automatic logic [7:0] port_oe_n(input logic [7:0] alt,
                                             input logic [7:0] alt_out,
                                             input logic [7:0] level);
        port_oe_n = (alt & ~alt_out) | (~alt & level);
    endfunction

    assign p0f = pins[7:0];
    assign p1f = pins[15:8];
    assign p2f = pins[23:16];
    assign adf = pins[39:24];
    assign sharedf = pins[41:40];
    assign fastf = pins[43:42];
    assign widthf = pins[44];
    assign hold_en = cfg[pamx_pkg::CFG_HOLD_EN];
    // Width only follows the pin when dynamic width is enabled.
    assign bus16_now = cfg[pamx_pkg::CFG_DYN_WIDTH] & widthf;
    // Hold request pin is active low.
    assign hold_req = hold_en & ~p1f[7];
    assign p1_alt = {hold_en, hold_en, hold_en,
                     cfg[pamx_pkg::CFG_PW2_EN],
                     cfg[pamx_pkg::CFG_PW1_EN], 3'b000};
    // A transfer completes at the edge where waitrequest is seen low.
    assign bus_take = (avs_read | avs_write) & ~avs_waitrequest;

    // Three-stage synchroniser; a bit changes once stages two and three
    // agree, which rejects a single-cycle glitch on the pin.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sync1 <= pamx_pkg::SYNC_RST;
            sync2 <= pamx_pkg::SYNC_RST;
            sync3 <= pamx_pkg::SYNC_RST;
            pins <= pamx_pkg::SYNC_RST;
        end else begin
            sync1 <= {bus_width_select_in, fast_pin_in, shared_in, ad_in,
                      p2_in, p1_in, p0_in};
            sync2 <= sync1;
            sync3 <= sync2;
            pins <= (sync2 & sync3) | (pins & (sync2 | sync3));
        end
    end

    // Bus slave handshake: waitrequest drops one cycle after a request
    // arrives and rises again at the completing edge.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
        end else begin
            avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
            if (avs_read & avs_waitrequest) begin
                avs_readdata <= next_readdata;
            end
        end
    end

    // Read decode; unmapped offsets read as zero.
    always_comb begin
        next_readdata = 32'h0000_0000;
        if (avs_address == pamx_pkg::OFF_CONFIG) begin
            next_readdata[8:0] = cfg;
        end else if (avs_address == pamx_pkg::OFF_P2_ALT) begin
            next_readdata[7:0] = p2_alt;
        end else if (avs_address == pamx_pkg::OFF_P1_LATCH) begin
            next_readdata[7:0] = p1_latch;
        end else if (avs_address == pamx_pkg::OFF_P2_LATCH) begin
            next_readdata[7:0] = p2_latch;
        end else if (avs_address == pamx_pkg::OFF_PINS) begin
            next_readdata[23:0] = {p2f, p1f, p0f};
        end else if (avs_address == pamx_pkg::OFF_STATUS) begin
            next_readdata[pamx_pkg::STAT_BUS16] = bus_16bit;
            next_readdata[pamx_pkg::STAT_HOLD] = hold_granted;
        end else if (avs_address == pamx_pkg::OFF_CAPTURE) begin
            next_readdata[15:0] = capture_value;
        end
    end

    // Register writes; writes to read-only or unmapped offsets are dropped.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cfg <= pamx_pkg::CONFIG_RST;
            p2_alt <= pamx_pkg::P2_ALT_RST;
            p1_latch <= pamx_pkg::LATCH_RST;
            p2_latch <= pamx_pkg::LATCH_RST;
        end else if (avs_write & bus_take) begin
            if (avs_address == pamx_pkg::OFF_CONFIG) begin
                cfg <= avs_writedata[8:0];
            end else if (avs_address == pamx_pkg::OFF_P2_ALT) begin
                p2_alt <= avs_writedata[7:0];
            end else if (avs_address == pamx_pkg::OFF_P1_LATCH) begin
                p1_latch <= avs_writedata[7:0];
            end else if (avs_address == pamx_pkg::OFF_P2_LATCH) begin
                p2_latch <= avs_writedata[7:0];
            end
        end
    end

    // Port zero: input-only unless the check-bit function is on, and then
    // only bits 0-3 and 6 ever drive; bits 4, 5 and 7 never do.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            p0_out <= 8'h00;
            p0_oe_n <= 8'hFF;
            ecc_check_bits <= 5'h00;
        end else begin
            p0_out <= {1'b0, ecc_check_drive[4], 2'b00,
                       ecc_check_drive[3:0]};
            if (cfg[pamx_pkg::CFG_ECC_EN] & ecc_check_oe) begin
                p0_oe_n <= 8'hB0;
            end else begin
                p0_oe_n <= 8'hFF;
            end
            ecc_check_bits <= {p0f[6], p0f[3:0]};
        end
    end

    // Port one output values: latch bits, or the alternate source.
    always_comb begin
        next_p1_out = p1_latch;
        if (cfg[pamx_pkg::CFG_PW1_EN]) begin
            next_p1_out[3] = pulse_width_out_one;
        end
        if (cfg[pamx_pkg::CFG_PW2_EN]) begin
            next_p1_out[4] = pulse_width_out_two;
        end
        if (hold_en) begin
            next_p1_out[5] = ~bus_req_pending;
            next_p1_out[6] = ~hold_granted;
            next_p1_out[7] = 1'b1;
        end
    end

    // Port two output values: transmit data and pwm zero when selected.
    always_comb begin
        next_p2_out = p2_latch;
        if (p2_alt[0]) begin
            next_p2_out[0] = serial_txd;
        end
        if (p2_alt[5]) begin
            next_p2_out[5] = pulse_width_out_zero;
        end
    end

    // Port one and two pin drivers; alternate outputs are full push-pull,
    // plain bits stay quasi-bidirectional so a pin written high can read.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            p1_out <= pamx_pkg::LATCH_RST;
            p1_oe_n <= 8'hFF;
            p2_out <= pamx_pkg::LATCH_RST;
            p2_oe_n <= 8'hFF;
        end else begin
            p1_out <= next_p1_out;
            p1_oe_n <= port_oe_n(p1_alt, 8'h78, next_p1_out);
            p2_out <= next_p2_out;
            p2_oe_n <= port_oe_n(p2_alt, 8'h21, next_p2_out);
        end
    end

    // Hold handover: grant only between bus cycles, keep the grant while
    // the request stands, so the device never cuts a cycle in two.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            hold_granted <= 1'b0;
        end else if (!hold_req) begin
            hold_granted <= 1'b0;
        end else if (!bus_cycle_active) begin
            hold_granted <= 1'b1;
        end
    end

    // Bus pin drive: address first, then write data or released for read.
    // In eight-bit mode the high byte carries address for the whole cycle.
    always_comb begin
        next_ad_out = bus_addr;
        next_ad_oe_n = 16'hFFFF;
        if (!hold_granted && bus_cycle_active) begin
            if (bus_addr_phase) begin
                next_ad_oe_n = 16'h0000;
            end else if (bus16_now) begin
                next_ad_out = bus_wdata;
                next_ad_oe_n = {16{~bus_data_write}};
            end else begin
                next_ad_out[7:0] = bus_wdata[7:0];
                next_ad_oe_n = {8'h00, {8{~bus_data_write}}};
            end
        end
    end

    // Registered bus pins, width flag and read data.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ad_out <= 16'h0000;
            ad_oe_n <= 16'hFFFF;
            bus_16bit <= 1'b0;
            bus_rdata <= 16'h0000;
        end else begin
            ad_out <= next_ad_out;
            ad_oe_n <= next_ad_oe_n;
            bus_16bit <= bus16_now;
            bus_rdata <= bus16_now ? adf : {8'h00, adf[7:0]};
        end
    end

    // Input routing to the interrupt, serial and timer units. Fast inputs
    // 0 and 1 may replace the port-two timer clock and reset pins.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            external_irq_input <= 1'b0;
            serial_rxd <= 1'b1;
            timer_two_clock_in <= 1'b0;
            baud_clock_in <= 1'b0;
            timer_two_reset_in <= 1'b0;
            timer_two_direction_in <= 1'b0;
            fast_input_low <= 2'b00;
            fast_input_high <= 2'b00;
        end else begin
            external_irq_input <= cfg[pamx_pkg::CFG_IRQ_SEL] ?
                                  p0f[7] : p2f[2];
            serial_rxd <= p2_alt[1] ? p2f[1] : 1'b1;
            baud_clock_in <= p2_alt[3] & p2f[3];
            timer_two_direction_in <= p2_alt[6] & p2f[6];
            if (cfg[pamx_pkg::CFG_FAST_T2]) begin
                timer_two_clock_in <= fastf[0];
                timer_two_reset_in <= fastf[1];
            end else begin
                timer_two_clock_in <= p2_alt[3] & p2f[3];
                timer_two_reset_in <= p2_alt[4] & p2f[4];
            end
            fast_input_low <= fastf;
            fast_input_high <= sharedf;
        end
    end

    // Shared fast pins: the output unit owns a pin only when selected,
    // otherwise it is released and the input unit reads it.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            shared_out <= 2'b00;
            shared_oe_n <= 2'b11;
        end else begin
            shared_out <= fast_output_high;
            shared_oe_n <= ~{cfg[pamx_pkg::CFG_FAST5_OUT],
                             cfg[pamx_pkg::CFG_FAST4_OUT]};
        end
    end

    // Capture on a rising edge of p2.7; the interrupt is a one-cycle pulse.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cap_prev <= 1'b1;
            capture_value <= 16'h0000;
            irq_vector_eleven <= 1'b0;
        end else begin
            cap_prev <= p2f[7];
            irq_vector_eleven <= p2_alt[7] & p2f[7] & ~cap_prev;
            if (p2_alt[7] & p2f[7] & ~cap_prev) begin
                capture_value <= timer_two_count;
            end
        end
    end

    default clocking dc @(posedge mclk); endclocking
    default disable iff (!reset_n);

    AST_P0_DEFAULT_INPUT: assert property (
        !cfg[pamx_pkg::CFG_ECC_EN] |=> p0_oe_n == 8'hFF)
        else $error("port zero drives while in default mode");
    AST_P0_PLAIN_BITS: assert property (
        p0_oe_n[7] && p0_oe_n[5:4] == 2'b11)
        else $error("port zero bit 4, 5 or 7 driven");
    AST_P1_QUASI_HIGH: assert property (
        !p1_alt[0] && p1_latch[0] |=> p1_oe_n[0])
        else $error("plain port one bit driven high");
    AST_IRQ_SOURCE: assert property (
        $past(reset_n) |-> external_irq_input ==
            ($past(cfg[pamx_pkg::CFG_IRQ_SEL]) ?
            $past(p0f[7]) : $past(p2f[2])))
        else $error("external irq from wrong pin");
    AST_PW1_ROUTE: assert property (
        cfg[pamx_pkg::CFG_PW1_EN] |=>
        !p1_oe_n[3] && p1_out[3] == $past(pulse_width_out_one))
        else $error("pwm one not on p1.3");
    AST_PW2_ROUTE: assert property (
        cfg[pamx_pkg::CFG_PW2_EN] |=>
        !p1_oe_n[4] && p1_out[4] == $past(pulse_width_out_two))
        else $error("pwm two not on p1.4");
    AST_BUS_REQUEST: assert property (
        hold_en && bus_req_pending |=> !p1_oe_n[5] && !p1_out[5])
        else $error("bus request not driven");
    AST_HOLD_RELEASE: assert property (
        hold_granted |=> ad_oe_n == 16'hFFFF && !p1_out[6])
        else $error("bus not released under hold");
    AST_CAPTURE: assert property (
        p2_alt[7] && p2f[7] && !cap_prev |=>
        irq_vector_eleven && capture_value == $past(timer_two_count))
        else $error("capture edge missed");
    AST_HIGH_BYTE_ADDR: assert property (
        bus_cycle_active && !hold_granted && !bus16_now |=>
        ad_oe_n[15:8] == 8'h00 && ad_out[15:8] == $past(bus_addr[15:8]))
        else $error("high byte not address in eight-bit mode");
    AST_WIDTH_LOCK: assert property (
        !cfg[pamx_pkg::CFG_DYN_WIDTH] |=> !bus_16bit)
        else $error("sixteen-bit width while locked");
    AST_SHARED_PIN: assert property (
        !cfg[pamx_pkg::CFG_FAST4_OUT] |=> shared_oe_n[0])
        else $error("shared pin driven while input");

    COV_HOLD_GRANT: cover property (hold_req ##[1:20] hold_granted);
    COV_CAPTURE: cover property (irq_vector_eleven);
    COV_BUS16_WRITE: cover property (bus16_now && bus_data_write);
    COV_REG_WRITE: cover property (avs_write && bus_take);
endmodule

/* File: test/pamx_far_side.sv */
// Purpose: Far side model: a bus-hold master plus external memory lines.
// Assumes: Hold request and acknowledge pins are active low.
// Notes: A released bus line reads back the inverse of the output register.
module pamx_far_side (
    // Clock, reset and bench control.
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic want_bus,
    // Board-level pins.
    input wire logic [15:0] ad_out,
    input wire logic [15:0] ad_oe_n,
    input wire logic ack_n,
    output logic hold_n,
    output logic [15:0] ad_in,
    output logic owns_bus
);
    // The request changes only just after an edge.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            hold_n <= 1'b1;
        end else begin
            hold_n <= !want_bus;
        end
    end
    // The bus counts as ours only after release is acknowledged.
    assign owns_bus = !hold_n && !ack_n;
    // A line shows its driver, else the inverse, so that a looped-back
    // value can never pass for read data.
    assign ad_in = ad_out ^ ad_oe_n;
endmodule

/* File: test/port_alternate_function_mux_bench.sv */
// Purpose: Self-checking bench for the alternate-function multiplexer.
// Assumes: Pin inputs settle within eight cycles of a change.
// Notes: Fast inputs ride along with the port-two random levels.
module port_alternate_function_mux_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, reset_n, avs_read, avs_write, avs_waitrequest;
    logic [4:0] avs_address, ecc_check_drive, ecc_check_bits;
    logic [31:0] avs_writedata, avs_readdata, seed, rd, v;
    logic [7:0] p0_in, p0_out, p0_oe_n, p1_in, p1_out, p1_oe_n;
    logic [7:0] p2_in, p2_out, p2_oe_n, p0_drv;
    logic [15:0] ad_in, ad_out, ad_oe_n, bus_addr, bus_wdata, bus_rdata;
    logic [15:0] timer_two_count;
    logic bus_width_select_in, bus_cycle_active, bus_addr_phase;
    logic bus_data_write, bus_req_pending, bus_16bit, hold_granted;
    logic [1:0] shared_out, shared_oe_n, fast_input_low, fast_input_high;
    logic [1:0] fast_output_high, fast_pin_in, shared_in;
    logic ecc_check_oe, pulse_width_out_zero, pulse_width_out_one;
    logic pulse_width_out_two, serial_txd, serial_rxd, external_irq_input;
    logic timer_two_clock_in, baud_clock_in, timer_two_reset_in;
    logic timer_two_direction_in, irq_vector_eleven;
    logic want_bus, hold_n, owns_bus;
    int error_cnt, checks_done, n;
    // Port zero pins resolve driver against p0_drv; port one bits 6-0 against the board pull-up, bit 7 comes from hold_n.
    assign p0_in = (p0_oe_n & p0_drv) | (~p0_oe_n & p0_out);
    assign p1_in = {hold_n, (p1_oe_n[6:0] | p1_out[6:0])};
    pamx_top i_pamx_top (.mclk, .reset_n, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
        .p0_in, .p0_out, .p0_oe_n, .p1_in, .p1_out, .p1_oe_n, .p2_in,
        .p2_out, .p2_oe_n, .ad_in, .ad_out, .ad_oe_n, .bus_width_select_in,
        .fast_pin_in, .shared_in, .shared_out, .shared_oe_n,
        .bus_cycle_active, .bus_addr_phase, .bus_data_write,
        .bus_req_pending, .bus_addr, .bus_wdata, .bus_rdata, .bus_16bit,
        .hold_granted, .ecc_check_drive, .ecc_check_oe, .ecc_check_bits,
        .pulse_width_out_zero, .pulse_width_out_one, .pulse_width_out_two,
        .serial_txd, .serial_rxd, .external_irq_input, .timer_two_clock_in,
        .baud_clock_in, .timer_two_reset_in, .timer_two_direction_in,
        .timer_two_count, .irq_vector_eleven, .fast_input_low,
        .fast_input_high, .fast_output_high);
    pamx_far_side i_pamx_far_side (.mclk, .reset_n, .want_bus, .ad_out,
        .ad_oe_n, .ack_n(p1_out[6]), .hold_n, .ad_in, .owns_bus);
    // Free-running 40 MHz clock.
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    // Xorshift step; the fixed seed keeps runs repeatable.
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // Expected interrupt source for a given select value.
    function automatic logic irq_src(logic sel, logic [7:0] a, logic [7:0] b);
        return sel ? a[7] : b[2];
    endfunction
    function automatic logic [31:0] bit_of(int i);
        return 32'h0000_0001 << i;
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    // One Avalon transfer; held until waitrequest is seen low.
    task automatic xfer(input logic w, input logic [4:0] a,
                        input logic [31:0] d);
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    // Let k edges pass, then look at settled outputs.
    task automatic settle(input int k);
        repeat (k) @(posedge mclk);
        @(negedge mclk);
    endtask
    task automatic print_verdict();
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Watchdog: far beyond the few hundred cycles the run needs.
    initial begin
        #200000;
        error_cnt++;
        print_verdict();
    end
    initial begin
        {avs_read, avs_write, avs_address, avs_writedata} = '0;
        {p0_drv, p2_in, bus_addr, bus_wdata, timer_two_count} = '0;
        {bus_width_select_in, bus_cycle_active, bus_addr_phase} = '0;
        {bus_data_write, bus_req_pending, ecc_check_drive} = '0;
        {ecc_check_oe, pulse_width_out_zero, pulse_width_out_one} = '0;
        {pulse_width_out_two, serial_txd, fast_output_high} = '0;
        {want_bus, shared_in, error_cnt, checks_done} = '0;
        seed = 32'h2422_6e3f;
        reset_n = 1'b0;
        settle(3);
        chk({p0_oe_n, p1_out, ad_oe_n}, 32'hFFFF_FFFF);
        chk({avs_waitrequest, serial_rxd}, 32'h0000_0003);
        @(posedge mclk);
        reset_n <= 1'b1;
        xfer(1'b0, pamx_pkg::OFF_P1_LATCH, 32'h0);
        chk(rd, 32'h0000_00FF);
        xfer(1'b0, 5'h1C, 32'h0);
        chk(rd, 32'h0000_0000);
        // Interrupt source follows the select bit both ways.
        for (int s = 0; s < 8; s++) begin
            xfer(1'b1, pamx_pkg::OFF_CONFIG, (s & 1) << pamx_pkg::CFG_IRQ_SEL);
            v = rnd();
            p0_drv <= v[7:0];
            p2_in <= v[15:8];
            settle(8);
            chk(external_irq_input, irq_src(s & 1, v[7:0], v[15:8]));
            chk(p0_oe_n, 32'h0000_00FF);
        end
        // Pulse-width takeover of port one bits 3 and 4.
        xfer(1'b1, pamx_pkg::OFF_CONFIG, bit_of(pamx_pkg::CFG_PW1_EN) |
             bit_of(pamx_pkg::CFG_PW2_EN) | bit_of(pamx_pkg::CFG_FAST4_OUT));
        for (int i = 0; i < 6; i++) begin
            v = rnd();
            @(posedge mclk);
            {pulse_width_out_two, pulse_width_out_one} <= v[1:0];
            fast_output_high <= v[3:2];
            settle(1);
            chk({p1_oe_n[4:3], p1_out[4:3]}, {2'b00, v[1:0]});
            chk({shared_oe_n[0], shared_out[0]}, {1'b0, v[2]});
        end
        // Quasi-bidirectional bits only pull low.
        xfer(1'b1, pamx_pkg::OFF_P1_LATCH, 32'h0000_0000);
        settle(1);
        chk({p1_oe_n[2:0], p1_out[2:0]}, 32'h0000_0000);
        xfer(1'b1, pamx_pkg::OFF_P1_LATCH, 32'h0000_00FF);
        settle(1);
        chk(p1_oe_n[2:0], 32'h0000_0007);
        // Port two alternate routes with random pin levels.
        xfer(1'b1, pamx_pkg::OFF_P2_ALT, 32'h0000_00FF);
        for (int i = 0; i < 6; i++) begin
            v = rnd();
            @(posedge mclk);
            p2_in <= {1'b0, v[6:0]};
            {serial_txd, pulse_width_out_zero} <= v[9:8];
            {shared_in, fast_pin_in} <= v[13:10];
            settle(8);
            chk({p2_oe_n[5], p2_oe_n[0], p2_out[5], p2_out[0]},
                {2'b00, v[8], v[9]});
            chk(serial_rxd, v[1]);
            chk({timer_two_clock_in, baud_clock_in}, {v[3], v[3]});
            chk(timer_two_direction_in, v[6]);
            chk(timer_two_reset_in, v[4]);
            chk({fast_input_high, fast_input_low}, v[13:10]);
        end
        xfer(1'b1, pamx_pkg::OFF_CONFIG, bit_of(pamx_pkg::CFG_FAST_T2));
        settle(1);
        chk({timer_two_reset_in, timer_two_clock_in}, v[11:10]);
        // Rising capture edge: one pulse, count latched.
        v = rnd();
        @(posedge mclk);
        timer_two_count <= v[15:0];
        p2_in[7] <= 1'b1;
        n = 0;
        repeat (12) begin
            @(negedge mclk);
            if (irq_vector_eleven === 1'b1) n++;
        end
        chk(n, 1);
        xfer(1'b0, pamx_pkg::OFF_CAPTURE, 32'h0);
        chk(rd, {16'h0000, v[15:0]});
        // Width is locked at eight bits unless dynamic width is on.
        @(posedge mclk);
        bus_width_select_in <= 1'b1;
        settle(8);
        chk(bus_16bit, 1'b0);
        xfer(1'b1, pamx_pkg::OFF_CONFIG, bit_of(pamx_pkg::CFG_DYN_WIDTH));
        settle(8);
        chk(bus_16bit, 1'b1);
        for (int w = 1; w >= 0; w--) begin
            v = rnd();
            @(posedge mclk);
            bus_width_select_in <= w[0];
            {bus_addr, bus_wdata} <= v;
            {bus_cycle_active, bus_addr_phase} <= 2'b11;
            settle(8);
            chk({ad_oe_n, ad_out}, {16'h0000, v[31:16]});
            @(posedge mclk);
            {bus_addr_phase, bus_data_write} <= {1'b0, w[0]};
            settle(8);
            chk(ad_oe_n, w ? 16'h0000 : 16'h00FF);
            chk(ad_out, w ? v[15:0] : {v[31:24], v[7:0]});
            chk(bus_rdata, w ? v[15:0] : {8'h00, ~v[7:0]});
        end
        @(posedge mclk);
        bus_cycle_active <= 1'b0;
        // Bus hold handover to the far-side master.
        xfer(1'b1, pamx_pkg::OFF_CONFIG, bit_of(pamx_pkg::CFG_HOLD_EN));
        @(posedge mclk);
        bus_req_pending <= 1'b1;
        want_bus <= 1'b1;
        settle(1);
        chk({p1_oe_n[5], p1_out[5]}, 32'h0000_0000);
        for (int i = 0; i < 20 && owns_bus !== 1'b1; i++) @(negedge mclk);
        chk({owns_bus, hold_granted, ad_oe_n}, 32'h0003_FFFF);
        @(posedge mclk);
        want_bus <= 1'b0;
        settle(12);
        chk({hold_granted, p1_out[6]}, 32'h0000_0001);
        // Check bits drive five pins of port zero.
        xfer(1'b1, pamx_pkg::OFF_CONFIG, bit_of(pamx_pkg::CFG_ECC_EN));
        v = rnd();
        @(posedge mclk);
        {ecc_check_oe, ecc_check_drive} <= {1'b1, v[4:0]};
        settle(8);
        chk(p0_oe_n, 32'h0000_00B0);
        chk(ecc_check_bits, v[4:0]);
        print_verdict();
    end
endmodule
